/* File: dctog_pkg.sv */
package dctog_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned DISCREP_MS = 500;
  localparam int unsigned BLOCK_MS = 10;
  localparam int unsigned DIAG_MS = 15;
  localparam int unsigned FILTER_US = 600;
  localparam int unsigned REARM_MS = 500;
  // Longest times round down, and the filter length, though a least time, rounds down too
  localparam int unsigned DISCREP_CYC = DISCREP_MS * (CLK_HZ / 1000);
  localparam int unsigned BLOCK_CYC = BLOCK_MS * (CLK_HZ / 1000);
  localparam int unsigned DIAG_CYC = DIAG_MS * (CLK_HZ / 1000);
  localparam int unsigned FILTER_CYC = FILTER_US * (CLK_HZ / 1000000);
  localparam int unsigned REARM_CYC = REARM_MS * (CLK_HZ / 1000);
  localparam logic [7:0] EVENT_NUM = 8'h32;
  localparam logic [3:0] EVENT_CAUSE = 4'h1;
  localparam logic CUTOFF_RST = 1'b1;
  typedef enum logic [1:0] {DCTOG_CUTOFF, DCTOG_RUN} dctog_state_e;
  typedef struct packed {
    logic a;
    logic b;
  } dctog_chan_s;
  typedef struct packed {
    logic [7:0] num;
    logic [3:0] cause;
  } dctog_event_s;
endpackage

/* File: dctog_gate.sv */
`timescale 1ns/10ps
// How it works
// RL1: Controller switches channels within 500 ms.
// RL2: Disagreement beyond limit raises event 50/1.
// RL3: Withdrawn inputs enter cutoff, block pulses.
// RL4: Pulses pass only while both asserted.
// RL5: Diagnosis output is NOR of inputs.
// RL6: Unused function: inputs held permanently asserted.
// RL7: Controller keeps channels off 500 ms; dctog_ctrl has no such hold and copies want_a/want_b at every edge.
// RL8: Pulses blocked within 10 ms.
// RL9: Diagnosis edge within 15 ms.
// RL10: Test pulses up to 600 us ignored.
module dctog_gate
  import dctog_pkg::*;
#(
  parameter int unsigned FILT_CYC = FILTER_CYC,
  parameter int unsigned DISC_CYC = DISCREP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Safety channel pins
  input wire logic channel_a_enable_input,
  input wire logic channel_b_enable_input,
  // Pulse patterns from control board, to power unit
  input wire logic [5:0] pulse_in,
  output logic [5:0] pulse_out,
  // Diagnosis
  output logic wiring_diag_output,
  output logic safe_torque_cutoff,
  output logic discrep_event,
  output dctog_event_s event_code
);
  dctog_chan_s s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
  dctog_chan_s filt_q, filt_d;
  logic [15:0] fa_q, fa_d, fb_q, fb_d;
  logic [24:0] dc_q, dc_d;
  dctog_state_e st_q, st_d;
  logic [5:0] po_q, po_d;
  logic diag_q, diag_d, cut_q, cut_d, ev_q, ev_d, evp_q, evp_d;
  // Event code kept in its own register so every output leaves a flip-flop
  dctog_event_s ec_q, ec_d;

  // Debounce step: accept a level only after FILT_CYC stable cycles
  function automatic logic [15:0] fstep(input logic agree, input logic same,
                                        input logic [15:0] c);
    if (!agree || same) fstep = 16'h0000;
    else if (c < 16'(FILT_CYC)) fstep = c + 16'h0001;
    else fstep = c;
  endfunction

  always_comb begin
    s1_d = '{a: channel_a_enable_input, b: channel_b_enable_input};
    s2_d = s1_q;
    s3_d = s2_q;
    filt_d = filt_q;
    fa_d = fstep(s2_q.a == s3_q.a, s3_q.a == filt_q.a, fa_q); // see RL10
    fb_d = fstep(s2_q.b == s3_q.b, s3_q.b == filt_q.b, fb_q); // see RL10
    if (fa_q == 16'(FILT_CYC)) filt_d.a = s3_q.a;
    if (fb_q == 16'(FILT_CYC)) filt_d.b = s3_q.b;
    // Discrepancy timer, restarts whenever channels agree
    dc_d = (filt_q.a == filt_q.b) ? 25'h0000000 : dc_q;
    evp_d = 1'b0;
    if (filt_q.a != filt_q.b && dc_q < 25'(DISC_CYC)) dc_d = dc_q + 25'h0000001;
    if (filt_q.a != filt_q.b && dc_q == 25'(DISC_CYC) - 25'h0000001) evp_d = 1'b1; // see RL2
    ev_d = ev_q | evp_d;
    if (filt_q.a == filt_q.b) ev_d = evp_d;
    // Code follows the flag in the same cycle, never lags it
    ec_d = ev_d ? '{num: EVENT_NUM, cause: EVENT_CAUSE} : '0; // see RL2
    st_d = st_q;
    case (st_q)
      DCTOG_CUTOFF: if (filt_q.a && filt_q.b) st_d = DCTOG_RUN; // see RL4
      DCTOG_RUN: if (!filt_q.a || !filt_q.b) st_d = DCTOG_CUTOFF; // see RL3
      default: st_d = DCTOG_CUTOFF;
    endcase
    // Gate also follows the filtered inputs directly, so cut_q rises the clock after an input drops
    cut_d = !(st_d == DCTOG_RUN && filt_q.a && filt_q.b);
    po_d = cut_q ? 6'h00 : pulse_in; // see RL8
    diag_d = !(filt_q.a | filt_q.b); // see RL5 RL9
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
      fa_q <= 16'h0000;
      fb_q <= 16'h0000;
      dc_q <= 25'h0000000;
      st_q <= DCTOG_CUTOFF;
      po_q <= 6'h00;
      diag_q <= 1'b1;
      cut_q <= CUTOFF_RST;
      ev_q <= 1'b0;
      evp_q <= 1'b0;
      ec_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      filt_q <= filt_d;
      fa_q <= fa_d;
      fb_q <= fb_d;
      dc_q <= dc_d;
      st_q <= st_d;
      po_q <= po_d;
      diag_q <= diag_d;
      cut_q <= cut_d;
      ev_q <= ev_d;
      evp_q <= evp_d;
      ec_q <= ec_d;
    end
  end

  assign pulse_out = po_q;
  assign wiring_diag_output = diag_q;
  assign safe_torque_cutoff = cut_q;
  assign discrep_event = ev_q;
  assign event_code = ec_q;

  property p_diag_nor;
    @(posedge clk) disable iff (reset) 1'b1 |=> diag_q == !($past(filt_q.a) | $past(filt_q.b));
  endproperty
  a_diag_nor: assert property (p_diag_nor) else $error("diag not NOR"); // see RL5

  sequence s_drop;
    !filt_q.a || !filt_q.b;
  endsequence
  property p_block;
    @(posedge clk) disable iff (reset) s_drop |=> cut_q ##1 pulse_out == 6'h00;
  endproperty
  a_block: assert property (p_block) else $error("pulses not blocked"); // see RL3 RL8

  property p_pass;
    @(posedge clk) disable iff (reset) !cut_q |-> filt_q.a && filt_q.b || $past(filt_q.a && filt_q.b);
  endproperty
  a_pass: assert property (p_pass) else $error("gate open without both"); // see RL4

  property p_event;
    @(posedge clk) disable iff (reset) $rose(ev_q) |-> filt_q.a != filt_q.b && event_code.num == EVENT_NUM;
  endproperty
  a_event: assert property (p_event) else $error("bad event"); // see RL2

  property p_filter;
    @(posedge clk) disable iff (reset) $changed(filt_q.a) |-> $past(fa_q) == 16'(FILT_CYC);
  endproperty
  a_filter: assert property (p_filter) else $error("filter too short"); // see RL10

  property p_diag_edge;
    @(posedge clk) disable iff (reset) $fell(filt_q.b) && !filt_q.a |=> ##[0:2] diag_q;
  endproperty
  a_diag_edge: assert property (p_diag_edge) else $error("no diag edge"); // see RL9

  property p_out_zero;
    @(posedge clk) disable iff (reset) $past(cut_q) |-> pulse_out == 6'h00;
  endproperty
  a_out_zero: assert property (p_out_zero) else $error("pulses leaked"); // see RL8

  property p_evclr;
    @(posedge clk) disable iff (reset) filt_q.a == filt_q.b && !evp_q |=> !ev_q;
  endproperty
  a_evclr: assert property (p_evclr) else $error("event stuck"); // see RL2

  // Shared building blocks for the gate and timer checks
  sequence s_open;
    filt_q.a && filt_q.b;
  endsequence
  sequence s_agree;
    filt_q.a == filt_q.b;
  endsequence
  sequence s_fall_a;
    $fell(filt_q.a);
  endsequence

  property p_diag_low;
    @(posedge clk) disable iff (reset) (filt_q.a || filt_q.b) |=> !diag_q;
  endproperty
  a_diag_low: assert property (p_diag_low) else $error("diag high with input on"); // see RL5

  property p_run_open;
    @(posedge clk) disable iff (reset) s_open ##0 st_q == DCTOG_RUN |=> !cut_q;
  endproperty
  a_run_open: assert property (p_run_open) else $error("gate shut while enabled"); // see RL4

  property p_rearm;
    @(posedge clk) disable iff (reset) s_open ##0 st_q == DCTOG_CUTOFF |=> st_q == DCTOG_RUN;
  endproperty
  a_rearm: assert property (p_rearm) else $error("no leave from cutoff"); // see RL4

  property p_ev_code;
    @(posedge clk) disable iff (reset)
      ev_q |-> event_code == '{num: EVENT_NUM, cause: EVENT_CAUSE};
  endproperty
  a_ev_code: assert property (p_ev_code) else $error("event code wrong"); // see RL2

  // The event must not come early: it rises at the edge where the timer reaches its limit
  property p_ev_time;
    @(posedge clk) disable iff (reset) $rose(ev_q) |-> $past(dc_q) == 25'(DISC_CYC) - 25'h0000001;
  endproperty
  a_ev_time: assert property (p_ev_time) else $error("event before limit"); // see RL2

  property p_dc_clear;
    @(posedge clk) disable iff (reset) s_agree |=> dc_q == 25'h0000000;
  endproperty
  a_dc_clear: assert property (p_dc_clear) else $error("timer not cleared"); // see RL2

  property p_pass_thru;
    @(posedge clk) disable iff (reset) !cut_q |=> pulse_out == $past(pulse_in);
  endproperty
  a_pass_thru: assert property (p_pass_thru) else $error("pulses not forwarded"); // see RL4

  // A short test pulse leaves the accepted level untouched
  property p_filt_hold;
    @(posedge clk) disable iff (reset) fa_q != 16'(FILT_CYC) |=> filt_q.a == $past(filt_q.a);
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter let pulse through"); // see RL10

  property p_filter_b;
    @(posedge clk) disable iff (reset) $changed(filt_q.b) |-> $past(fb_q) == 16'(FILT_CYC);
  endproperty
  a_filter_b: assert property (p_filter_b) else $error("filter b too short"); // see RL10

  property p_block_a;
    @(posedge clk) disable iff (reset) s_fall_a |-> ##[1:2] pulse_out == 6'h00;
  endproperty
  a_block_a: assert property (p_block_a) else $error("pulses not blocked on a"); // see RL8

  property p_diag_edge_a;
    @(posedge clk) disable iff (reset) s_fall_a ##0 !filt_q.b |=> ##[0:2] diag_q;
  endproperty
  a_diag_edge_a: assert property (p_diag_edge_a) else $error("no diag edge on a"); // see RL9
endmodule // dctog_gate

/* File: dctog_ctrl.sv */
`timescale 1ns/10ps
module dctog_ctrl (
  // Clock
  input wire logic clk,
  // Commands
  input wire logic want_a,
  input wire logic want_b,
  // Channel pins
  output logic chan_a = 1'b0,
  output logic chan_b = 1'b0
);
  // Both channels move at one edge, so skew stays far under the limit
  always @(posedge clk) begin
    chan_a <= #1 want_a;
    chan_b <= #1 want_b;
  end
endmodule // dctog_ctrl

/* File: dctog_gate_tb.sv */
`timescale 1ns/10ps
module dctog_gate_tb;
  import dctog_pkg::*;
  logic clk = 1'b0, reset = 1'b1, want_a = 1'b0, want_b = 1'b0;
  logic chan_a, chan_b, diag, cut, ev;
  logic [5:0] pin = 6'h2A, pout;
  dctog_event_s code;
  int miscompares = 0, n_checks = 0;
  dctog_gate #(.FILT_CYC(8), .DISC_CYC(40)) dut (.clk(clk), .reset(reset),
    .channel_a_enable_input(chan_a), .channel_b_enable_input(chan_b), .pulse_in(pin),
    .pulse_out(pout), .wiring_diag_output(diag), .safe_torque_cutoff(cut),
    .discrep_event(ev), .event_code(code));
  dctog_ctrl ctrl (.clk(clk), .want_a(want_a), .want_b(want_b), .chan_a(chan_a),
    .chan_b(chan_b));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    check("cut", cut, 1'b1);
    check("diag", diag, 1'b1);
    check("pout", pout, 6'h00);
    $display("test reset done");
  endtask
  task automatic t_run();
    want_a = 1'b1;
    want_b = 1'b1;
    idle(20);
    check("cut", cut, 1'b0);
    check("diag", diag, 1'b0);
    pin = 6'h15;
    idle(2);
    check("pout", pout, 6'h15);
    $display("test run done");
  endtask
  task automatic t_glitch();
    want_a = 1'b0;
    idle(4);
    want_a = 1'b1;
    idle(20);
    check("cut", cut, 1'b0);
    $display("test glitch done");
  endtask
  task automatic t_split();
    want_a = 1'b0;
    idle(20);
    check("pout", pout, 6'h00);
    check("diag", diag, 1'b0);
    check("ev", ev, 1'b0);
    idle(50);
    check("ev", ev, 1'b1);
    check("code", code, {EVENT_NUM, EVENT_CAUSE});
    want_b = 1'b0;
    idle(20);
    check("diag", diag, 1'b1);
    check("ev", ev, 1'b0);
    want_b = 1'b1;
    idle(20);
    check("diag", diag, 1'b0);
    want_a = 1'b1;
    idle(20);
    check("cut", cut, 1'b0);
    $display("test split done");
  endtask
  task automatic t_rst2();
    reset = 1'b1;
    idle(2);
    check("cut", cut, 1'b1);
    check("pout", pout, 6'h00);
    check("ev", ev, 1'b0);
    reset = 1'b0;
    idle(2);
    check("cut", cut, 1'b1);
    idle(20);
    check("cut", cut, 1'b0);
    $display("test mid reset done");
  endtask
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end
  initial begin
    idle(20);
    t_reset();
    reset = 1'b0;
    idle(2);
    t_run();
    t_glitch();
    t_split();
    t_rst2();
    stop_test();
  end
endmodule // dctog_gate_tb
